// *** rtl/pss_sequencer.sv ***
// Purpose: Sequences normal, battery and sleep power states and keeps the retained registers
// Assumes: rstn_i is the power-on reset of the always-on domain; sfr port is on mclk_i
// Notes: Retained registers clear only on rstn_i, never on sleep or wake
`include "pss_defines.svh"
`default_nettype none

// How it works
// - Normal state feeds switched supply from main and enables both domains.
// - Power-on or software reset selects the 1.024 MHz core clock.
// - Battery state feeds from battery, keeps core and digital, drops analog.
// - Return to main only when main above 2.75 V and metering power-down clear.
// - Sleep feeds from battery and shuts every 2.5 V domain including core.
// - Processor RAM is flagged lost once sleep is entered.
// - Wake from sleep restarts the core at the reset vector.
// - Thermal, supply, calendar and display stay powered in sleep per configuration.
// - Sleep ends only on a wake event, external reset low or supply restore conditions.
// - Four scratch registers at 0xfb to 0xfe survive sleep.
// - Listed configuration and value registers survive sleep.
// - Indirect calendar registers survive sleep.
// - Bit 6 of the wake source register shows main supply as 1.
// - Wait 130 ms after restore conditions before switching back to main.
// - External reset low during sleep wakes into the battery state.
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int unsigned RESTORE_CYC = `PSS_RESTORE_CYC,
   parameter int unsigned WAKE_HOLD_CYC = `PSS_WAKE_HOLD_CYC,
   parameter int unsigned CAL_IND_DEPTH = 16
) (
   // Clock, reset, enable
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // Supply monitors and pins (asynchronous)
   input wire logic vdd_ok_i,
   input wire logic supply_input_voltage_ok_i,
   input wire logic ext_rst_n_i,
   input wire logic wake_event_i,
   // Core side controls
   input wire logic metering_power_down_bit_i,
   input wire logic sleep_req_i,
   input wire logic soft_reset_i,
   input wire logic clk_sel_we_i,
   input wire logic [2:0] clk_sel_i,
   input wire logic ram_lost_clr_i,
   // Register port
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_we_i,
   input wire logic sfr_re_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   // Converter results
   input wire logic therm_val_we_i,
   input wire logic [7:0] therm_val_i,
   input wire logic cell_val_we_i,
   input wire logic [7:0] cell_val_i,
   input wire logic supply_val_we_i,
   input wire logic [7:0] supply_val_i,
   // Indirect calendar registers
   input wire logic [$clog2(CAL_IND_DEPTH)-1:0] cal_ind_addr_i,
   input wire logic cal_ind_we_i,
   input wire logic [7:0] cal_ind_wdata_i,
   output logic [7:0] cal_ind_rdata_o,
   // Power controls
   output logic switched_supply_main_o,
   output logic internal_analog_domain_en_o,
   output logic internal_digital_domain_en_o,
   output logic core_rst_n_o,
   output logic core_restart_o,
   output logic [2:0] core_clk_sel_o,
   output logic ram_lost_o,
   output logic [2:0] power_state_o,
   // Always-on peripheral enables
   output logic therm_conv_en_o,
   output logic supply_conv_en_o,
   output logic calendar_en_o,
   output logic segment_disp_en_o
);

   localparam int NREG = 28;
   localparam int CW = 24;

   // Pin synchronisers: first stage is read only by the second
   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         // Reset to idle pin levels, otherwise a false supply loss and
         // a false external reset would be seen right after reset
         meta_ff <= `PSS_PIN_IDLE;
         sync_ff <= `PSS_PIN_IDLE;
      end else if (ce_i) begin
         meta_ff <= {wake_event_i, ext_rst_n_i, supply_input_voltage_ok_i, vdd_ok_i};
         sync_ff <= meta_ff;
      end
   end

   wire vdd_ok = sync_ff[0];
   wire supply_input_voltage_ok = sync_ff[1];
   wire ext_rst_low = ~sync_ff[2];
   wire wake_ev = sync_ff[3];

   // Register index of an address; 5'h1f means unmapped
   function automatic logic [4:0] reg_index(input logic [7:0] a);
      logic [4:0] i;
      i = 5'h1f;
      unique case (a)
         `PSS_SEG_CFG_ADDR: i = 5'h00;
         `PSS_SEG_CLK_ADDR: i = 5'h01;
         `PSS_SEG_EN_LO_ADDR: i = 5'h02;
         `PSS_SEG_CFG_X_ADDR: i = 5'h03;
         `PSS_CAL_CFG_ADDR: i = 5'h04;
         `PSS_CAL_CFG2_ADDR: i = 5'h05;
         `PSS_SEG_PTR_ADDR: i = 5'h06;
         `PSS_SEG_VAL_ADDR: i = 5'h07;
         `PSS_SEG_CFG_Y_ADDR: i = 5'h08;
         `PSS_P0_PULL_ADDR: i = 5'h09;
         `PSS_P1_PULL_ADDR: i = 5'h0a;
         `PSS_P2_PULL_ADDR: i = 5'h0b;
         `PSS_THERM_VAL_ADDR: i = 5'h0c;
         `PSS_CELL_VAL_ADDR: i = 5'h0d;
         `PSS_SEG_EN_HI_ADDR: i = 5'h0e;
         `PSS_SUPPLY_VAL_ADDR: i = 5'h0f;
         `PSS_DELTA_CFG_ADDR: i = 5'h10;
         `PSS_WAKE_CFG_ADDR: i = 5'h11;
         `PSS_SWITCH_CFG_ADDR: i = 5'h12;
         `PSS_NOM_TRIM_ADDR: i = 5'h13;
         `PSS_THERM_TRIM_ADDR: i = 5'h14;
         `PSS_STROBE_PER_ADDR: i = 5'h15;
         `PSS_CELL_LOW_ADDR: i = 5'h16;
         `PSS_STORE1_ADDR: i = 5'h17;
         `PSS_STORE2_ADDR: i = 5'h18;
         `PSS_STORE3_ADDR: i = 5'h19;
         `PSS_STORE4_ADDR: i = 5'h1a;
         `PSS_IRQ_PIN_ADDR: i = 5'h1b;
         default: i = 5'h1f;
      endcase
      return i;
   endfunction : reg_index

   localparam logic [4:0] IX_SEG_CFG = 5'h00;
   localparam logic [4:0] IX_CAL_CFG = 5'h04;
   localparam logic [4:0] IX_THERM = 5'h0c;
   localparam logic [4:0] IX_CELL = 5'h0d;
   localparam logic [4:0] IX_SUPPLY = 5'h0f;
   localparam logic [4:0] IX_DELTA = 5'h10;
   localparam logic [4:0] IX_WAKE = 5'h11;
   localparam logic [4:0] IX_SWITCH = 5'h12;

   // Address decode
   wire [4:0] sfr_idx = reg_index(sfr_addr_i);
   wire sfr_mapped = (sfr_idx != 5'h1f);
   wire sfr_ro = (sfr_idx == IX_THERM) || (sfr_idx == IX_CELL) || (sfr_idx == IX_SUPPLY);
   wire sfr_wr_ok = sfr_we_i && sfr_mapped && !sfr_ro;

   // Retained register file: reset only by power-on, untouched by sleep
   pss_byte_type regs_ff [NREG];
   pss_byte_type nxt_regs [NREG];
   logic sw_main_ff;

   always_comb begin
      for (int k = 0; k < NREG; k++) begin
         nxt_regs[k] = regs_ff[k];
      end
      if (sfr_wr_ok) begin
         nxt_regs[sfr_idx] = sfr_wdata_i;
      end
      if (therm_val_we_i) begin
         nxt_regs[IX_THERM] = therm_val_i;
      end
      if (cell_val_we_i) begin
         nxt_regs[IX_CELL] = cell_val_i;
      end
      if (supply_val_we_i) begin
         nxt_regs[IX_SUPPLY] = supply_val_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         for (int k = 0; k < NREG; k++) begin
            regs_ff[k] <= `PSS_REG_RST;
         end
      end else if (ce_i) begin
         for (int k = 0; k < NREG; k++) begin
            regs_ff[k] <= nxt_regs[k];
         end
      end
   end

   // Source status bit is live hardware state, not a stored bit
   wire [7:0] wake_cfg_view = {regs_ff[IX_WAKE][7], sw_main_ff, regs_ff[IX_WAKE][5:0]};
   wire [7:0] rd_mux = !sfr_mapped ? 8'h00 : (sfr_idx == IX_WAKE) ? wake_cfg_view : regs_ff[sfr_idx];

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o <= 1'b0;
      end else if (ce_i) begin
         sfr_rdata_o <= sfr_re_i ? rd_mux : 8'h00;
         sfr_hit_o <= sfr_re_i && sfr_mapped;
      end
   end

   // Indirect calendar registers, also retained
   logic [7:0] cal_ind_ff [CAL_IND_DEPTH];
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         for (int k = 0; k < CAL_IND_DEPTH; k++) begin
            cal_ind_ff[k] <= `PSS_REG_RST;
         end
         cal_ind_rdata_o <= 8'h00;
      end else if (ce_i) begin
         if (cal_ind_we_i) begin
            cal_ind_ff[cal_ind_addr_i] <= cal_ind_wdata_i;
         end
         cal_ind_rdata_o <= cal_ind_ff[cal_ind_addr_i];
      end
   end

   // Restore conditions depend on the switchover selection
   wire [1:0] switch_sel = regs_ff[IX_SWITCH][`PSS_SWITCH_SEL_LSB +: 2];
   // With 01 both supplies must be good before the restore wait may start
   wire need_supply_input_voltage = (switch_sel == `PSS_SWITCH_VDD_SUPPLY_INPUT_VOLTAGE);
   wire supply_good = vdd_ok && (!need_supply_input_voltage || supply_input_voltage_ok);
   wire restore_ok = supply_good && !metering_power_down_bit_i;
   wire supply_fail = !supply_good;

   // State machine
   pss_state_type state_ff;
   pss_state_type nxt_state;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic wake_to_main_ff;
   logic nxt_wake_to_main;
   wire restore_done = (cnt_ff >= CW'(RESTORE_CYC - 1));
   wire hold_done = (cnt_ff >= CW'(WAKE_HOLD_CYC - 1));

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 1'b1;
      nxt_wake_to_main = wake_to_main_ff;
      unique case (state_ff)
         PSS_NORMAL: begin
            nxt_cnt = '0;
            if (supply_fail) begin
               nxt_state = PSS_BATTERY;
            end
         end
         PSS_BATTERY: begin
            nxt_cnt = '0;
            if (sleep_req_i) begin
               nxt_state = PSS_SLEEP;
            end else if (restore_ok) begin
               nxt_state = PSS_RESTORE_WAIT;
            end
         end
         PSS_RESTORE_WAIT: begin
            if (!restore_ok) begin
               nxt_state = PSS_BATTERY;
               nxt_cnt = '0;
            end else if (restore_done) begin
               nxt_state = PSS_NORMAL;
               nxt_cnt = '0;
            end
         end
         PSS_SLEEP: begin
            nxt_cnt = '0;
            // Only wake events, external reset or supply restore end sleep
            if (ext_rst_low) begin
               nxt_state = PSS_WAKE;
               nxt_wake_to_main = 1'b0;
            end else if (wake_ev || restore_ok) begin
               nxt_state = PSS_WAKE;
               nxt_wake_to_main = 1'b0;
            end
         end
         PSS_WAKE: begin
            if (hold_done) begin
               nxt_state = nxt_wake_to_main ? PSS_NORMAL : PSS_BATTERY;
               nxt_cnt = '0;
            end
         end
      endcase
   end

   // Power outputs derived from next state so they register with it
   wire nxt_main = (nxt_state == PSS_NORMAL);
   wire nxt_analog = (nxt_state == PSS_NORMAL);
   wire nxt_digital = (nxt_state != PSS_SLEEP);
   wire nxt_core_rst_n = (nxt_state != PSS_SLEEP) && (nxt_state != PSS_WAKE);
   wire entering_sleep = (nxt_state == PSS_SLEEP) && (state_ff != PSS_SLEEP);
   wire leaving_wake = (state_ff == PSS_WAKE) && (nxt_state != PSS_WAKE);

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         state_ff <= PSS_NORMAL;
         cnt_ff <= '0;
         wake_to_main_ff <= 1'b0;
      end else if (ce_i) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wake_to_main_ff <= nxt_wake_to_main;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sw_main_ff <= 1'b1;
         internal_analog_domain_en_o <= 1'b1;
         internal_digital_domain_en_o <= 1'b1;
         core_rst_n_o <= 1'b1;
         core_restart_o <= 1'b0;
      end else if (ce_i) begin
         sw_main_ff <= nxt_main;
         internal_analog_domain_en_o <= nxt_analog;
         internal_digital_domain_en_o <= nxt_digital;
         core_rst_n_o <= nxt_core_rst_n;
         core_restart_o <= leaving_wake;
      end
   end

   assign switched_supply_main_o = sw_main_ff;
   assign power_state_o = 3'(state_ff);

   // Core clock select returns to default whenever the core restarts
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         core_clk_sel_o <= `PSS_CLK_SEL_1024K;
      end else if (ce_i) begin
         if (soft_reset_i || leaving_wake) begin
            core_clk_sel_o <= `PSS_CLK_SEL_1024K;
         end else if (clk_sel_we_i) begin
            core_clk_sel_o <= clk_sel_i;
         end
      end
   end

   // RAM lost flag: set beats clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ram_lost_o <= 1'b0;
      end else if (ce_i) begin
         if (entering_sleep) begin
            ram_lost_o <= 1'b1;
         end else if (ram_lost_clr_i) begin
            ram_lost_o <= 1'b0;
         end
      end
   end

   // Always-on peripherals follow configuration written while the core ran
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         therm_conv_en_o <= 1'b0;
         supply_conv_en_o <= 1'b0;
         calendar_en_o <= 1'b0;
         segment_disp_en_o <= 1'b0;
      end else if (ce_i) begin
         therm_conv_en_o <= regs_ff[IX_DELTA][`PSS_THERM_EN_BIT];
         supply_conv_en_o <= regs_ff[IX_DELTA][`PSS_SUPPLY_EN_BIT];
         calendar_en_o <= regs_ff[IX_CAL_CFG][`PSS_CAL_EN_BIT];
         segment_disp_en_o <= regs_ff[IX_SEG_CFG][`PSS_SEG_EN_BIT];
      end
   end

endmodule : pss_sequencer
`default_nettype wire

// *** rtl/pss_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the power state sequencer
// Assumes: 8-bit special function register space, 125 MHz sequencer clock
// Notes: Definitions only
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Register offsets
`define PSS_SEG_CFG_ADDR 8'h95
`define PSS_SEG_CLK_ADDR 8'h96
`define PSS_SEG_EN_LO_ADDR 8'h97
`define PSS_SEG_CFG_X_ADDR 8'h9c
`define PSS_CAL_CFG_ADDR 8'ha1
`define PSS_CAL_CFG2_ADDR 8'ha2
`define PSS_SEG_PTR_ADDR 8'hac
`define PSS_SEG_VAL_ADDR 8'hae
`define PSS_SEG_CFG_Y_ADDR 8'hb1
`define PSS_P0_PULL_ADDR 8'hb2
`define PSS_P1_PULL_ADDR 8'hb3
`define PSS_P2_PULL_ADDR 8'hb4
`define PSS_THERM_VAL_ADDR 8'hd7
`define PSS_CELL_VAL_ADDR 8'hdf
`define PSS_SEG_EN_HI_ADDR 8'hed
`define PSS_SUPPLY_VAL_ADDR 8'hef
`define PSS_DELTA_CFG_ADDR 8'hf3
`define PSS_WAKE_CFG_ADDR 8'hf4
`define PSS_SWITCH_CFG_ADDR 8'hf5
`define PSS_NOM_TRIM_ADDR 8'hf6
`define PSS_THERM_TRIM_ADDR 8'hf7
`define PSS_STROBE_PER_ADDR 8'hf9
`define PSS_CELL_LOW_ADDR 8'hfa
`define PSS_STORE1_ADDR 8'hfb
`define PSS_STORE2_ADDR 8'hfc
`define PSS_STORE3_ADDR 8'hfd
`define PSS_STORE4_ADDR 8'hfe
`define PSS_IRQ_PIN_ADDR 8'hff

// Field positions
`define PSS_SRC_STATUS_BIT 6
`define PSS_SWITCH_SEL_LSB 0
`define PSS_THERM_EN_BIT 0
`define PSS_SUPPLY_EN_BIT 1
`define PSS_CAL_EN_BIT 0
`define PSS_SEG_EN_BIT 7

// Reset values
`define PSS_REG_RST 8'h00
`define PSS_CLK_SEL_1024K 3'h3
`define PSS_SWITCH_VDD_ONLY 2'h0
`define PSS_SWITCH_VDD_SUPPLY_INPUT_VOLTAGE 2'h1
// Idle levels of the synchronised pins: wake low, reset pin high, supplies good
`define PSS_PIN_IDLE 4'h7

// Timing
`define PSS_CLK_MHZ 125
`define PSS_RESTORE_MS 130
`define PSS_RESTORE_CYC (`PSS_RESTORE_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_WAKE_HOLD_CYC 16

`endif

// *** rtl/pss_pkg.sv ***
// Purpose: Types of the power state sequencer
// Assumes: Nothing beyond the defines header
// Notes: Power states of the sequencer
`default_nettype none
package pss_pkg;
   typedef enum logic [2:0] {
      PSS_NORMAL,
      PSS_BATTERY,
      PSS_RESTORE_WAIT,
      PSS_SLEEP,
      PSS_WAKE
   } pss_state_type;
   typedef logic [7:0] pss_byte_type;
endpackage : pss_pkg
`default_nettype wire

// *** dv/pss_sequencer_checker.sv ***
// Purpose: Port assertions of the power state sequencer
// Assumes: power_state_o holds pss_state_type codes
// Notes: Levels per state are checked every cycle, not only at transitions
`default_nettype none
module pss_sequencer_checker (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic sfr_re_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic sfr_hit_o,
   // Power controls
   input wire logic switched_supply_main_o,
   input wire logic internal_analog_domain_en_o,
   input wire logic internal_digital_domain_en_o,
   input wire logic core_rst_n_o,
   input wire logic core_restart_o,
   input wire logic [2:0] core_clk_sel_o,
   input wire logic ram_lost_o,
   input wire logic [2:0] power_state_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   wire logic [3:0] lvl = {switched_supply_main_o, internal_analog_domain_en_o, internal_digital_domain_en_o,
      core_rst_n_o};
   chk_normal_levels: assert property (power_state_o == 3'h0 |-> lvl == 4'hf)
      else $error("normal state levels wrong");
   chk_battery_levels: assert property (power_state_o == 3'h1 |-> lvl == 4'h3)
      else $error("battery state levels wrong");
   chk_sleep_levels: assert property (power_state_o == 3'h3 |-> lvl == 4'h0)
      else $error("sleep state levels wrong");
   chk_sleep_ram_lost: assert property (power_state_o == 3'h3 |-> ram_lost_o)
      else $error("ram not flagged lost in sleep");
   chk_sleep_exit_wake: assert property (power_state_o == 3'h3 |=> power_state_o inside {3'h3, 3'h4})
      else $error("sleep left without wake");
   chk_wake_core_reset: assert property (power_state_o == 3'h4 |-> !core_rst_n_o && internal_digital_domain_en_o)
      else $error("core reset wrong during wake");
   chk_restart_vector: assert property (core_restart_o |-> $past(power_state_o) == 3'h4 && power_state_o == 3'h1)
      else $error("restart pulse outside wake exit");
   chk_restart_clock: assert property (core_restart_o |-> core_clk_sel_o == 3'h3)
      else $error("core clock not default on restart");
   chk_normal_entry: assert property (power_state_o == 3'h0 && $past(power_state_o) != 3'h0
      |-> $past(power_state_o) == 3'h2)
      else $error("normal entered without restore wait");
   chk_source_bit: assert property ($past(sfr_re_i) && $past(sfr_addr_i) == 8'hf4
      |-> sfr_hit_o && sfr_rdata_o[6] == $past(switched_supply_main_o))
      else $error("supply source bit wrong");
   cover property (power_state_o == 3'h3);
   cover property (core_restart_o);
   cover property (power_state_o == 3'h2 ##1 power_state_o == 3'h0);
endmodule : pss_sequencer_checker

bind pss_sequencer pss_sequencer_checker u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .sfr_re_i(sfr_re_i),
   .sfr_addr_i(sfr_addr_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
   .switched_supply_main_o(switched_supply_main_o), .internal_analog_domain_en_o(internal_analog_domain_en_o),
   .internal_digital_domain_en_o(internal_digital_domain_en_o), .core_rst_n_o(core_rst_n_o),
   .core_restart_o(core_restart_o), .core_clk_sel_o(core_clk_sel_o), .ram_lost_o(ram_lost_o),
   .power_state_o(power_state_o));
`default_nettype wire

// *** dv/pss_sequencer_bench.sv ***
// Purpose: Self-checking bench of the power state sequencer
// Assumes: Restore wait shortened to RC cycles
// Notes: Inputs change 1 ns after the rising edge
`default_nettype none
module pss_sequencer_bench
   import pss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RC = 20;
   logic mclk_i;
   logic rstn_i = 0, vdd = 1, ext_n = 1, wake = 0, met = 0, slp = 0, srst = 0, csw = 0, rclr = 0;
   logic we = 0, re = 0, tw = 0, cw = 0, vdc = 1;
   logic [2:0] cs = 3'h0;
   logic [3:0] ca = 4'h0;
   logic [7:0] sa = 8'h00, wd = 8'h00, tv = 8'h00, cd = 8'h00;
   wire logic [7:0] rd, crd;
   wire logic hit, main, ana, dig, crn, rsp, rl, te, se, cal, seg;
   wire logic [2:0] cks, st;
   int fails = 0, num_checks = 0;

   pss_sequencer #(.RESTORE_CYC(RC)) uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .vdd_ok_i(vdd),
      .supply_input_voltage_ok_i(vdc), .ext_rst_n_i(ext_n), .wake_event_i(wake), .metering_power_down_bit_i(met),
      .sleep_req_i(slp), .soft_reset_i(srst), .clk_sel_we_i(csw), .clk_sel_i(cs), .ram_lost_clr_i(rclr),
      .sfr_addr_i(sa), .sfr_we_i(we), .sfr_re_i(re), .sfr_wdata_i(wd), .sfr_rdata_o(rd), .sfr_hit_o(hit),
      .therm_val_we_i(tw), .therm_val_i(tv), .cell_val_we_i(1'b0), .cell_val_i(8'h00), .supply_val_we_i(1'b0),
      .supply_val_i(8'h00), .cal_ind_addr_i(ca), .cal_ind_we_i(cw), .cal_ind_wdata_i(cd), .cal_ind_rdata_o(crd),
      .switched_supply_main_o(main), .internal_analog_domain_en_o(ana), .internal_digital_domain_en_o(dig),
      .core_rst_n_o(crn), .core_restart_o(rsp), .core_clk_sel_o(cks), .ram_lost_o(rl), .power_state_o(st),
      .therm_conv_en_o(te), .supply_conv_en_o(se), .calendar_en_o(cal), .segment_disp_en_o(seg));

   initial begin
      mclk_i = 0;
      forever #4 mclk_i = ~mclk_i;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sa = a;
      wd = d;
      we = 1;
      tick(1);
      we = 0;
      tick(1);
   endtask : wr

   // Read data stands one cycle only, so it is judged right after the read edge
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      sa = a;
      re = 1;
      tick(1);
      re = 0;
      check(rd & m, e);
      tick(1);
   endtask : rdc

   task automatic wait_st(input logic [2:0] s);
      for (int i = 0; i < 400 && st !== s; i++) tick(1);
      check({5'h0, st}, {5'h0, s});
   endtask : wait_st

   task automatic t_regs;
      check({main, ana, dig, crn, 1'b0, cks}, 8'hf3);
      for (int i = 0; i < 4; i++) wr(8'hfb + 8'(i), 8'ha0 + 8'(i));
      wr(8'hf3, 8'h03);
      wr(8'ha1, 8'h01);
      wr(8'h95, 8'h80);
      wr(8'hf4, 8'h00);
      tv = 8'h3c;
      tw = 1;
      tick(1);
      tw = 0;
      wr(8'hd7, 8'hff);
      rdc(8'hf4, 8'h40, 8'h40);
      rdc(8'hd7, 8'h3c, 8'hff);
      // Unmapped read: hit and data judged while the answer stands
      sa = 8'h00;
      re = 1;
      tick(1);
      re = 0;
      check({7'h0, hit}, 8'h00);
      check(rd, 8'h00);
      tick(1);
      ca = 4'h3;
      cd = 8'h5c;
      cw = 1;
      tick(1);
      cw = 0;
      cs = 3'h5;
      csw = 1;
      tick(1);
      csw = 0;
      tick(1);
      check({5'h0, cks}, 8'h05);
      srst = 1;
      tick(1);
      srst = 0;
      tick(1);
      check({5'h0, cks}, 8'h03);
      $display("registers done");
   endtask : t_regs

   task automatic t_battery;
      vdd = 0;
      wait_st(PSS_BATTERY);
      check({4'h0, main, ana, dig, crn}, 8'h03);
      rdc(8'hf4, 8'h00, 8'h40);
      met = 1;
      vdd = 1;
      tick(40);
      check({5'h0, st}, {5'h0, PSS_BATTERY});
      // Both supplies required: a low second supply blocks the return
      wr(8'hf5, 8'h01);
      vdc = 0;
      tick(3);
      met = 0;
      tick(40);
      check({5'h0, st}, {5'h0, PSS_BATTERY});
      vdd = 0;
      vdc = 1;
      tick(4);
      $display("battery done");
   endtask : t_battery

   task automatic t_sleep(input logic by_ext);
      cs = 3'h6;
      csw = 1;
      tick(1);
      csw = 0;
      slp = 1;
      tick(1);
      slp = 0;
      wait_st(PSS_SLEEP);
      check({4'h0, main, ana, dig, crn}, 8'h00);
      check({7'h0, rl}, 8'h01);
      check({4'h0, te, se, cal, seg}, 8'h0f);
      tick(60);
      check({5'h0, st}, {5'h0, PSS_SLEEP});
      if (by_ext) begin
         ext_n = 0;
      end else begin
         wake = 1;
      end
      tick(3);
      ext_n = 1;
      wake = 0;
      wait_st(PSS_WAKE);
      check({7'h0, crn}, 8'h00);
      for (int i = 0; i < 40 && rsp !== 1'b1; i++) tick(1);
      check({7'h0, rsp}, 8'h01);
      check({2'h0, st, cks}, {2'h0, PSS_BATTERY, 3'h3});
      check({7'h0, crn}, 8'h01);
      cs = 3'h2;
      csw = 1;
      tick(1);
      csw = 0;
      check({5'h0, cks}, 8'h02);
      rclr = 1;
      tick(1);
      rclr = 0;
      tick(1);
      check({7'h0, rl}, 8'h00);
      $display("sleep done");
   endtask : t_sleep

   task automatic t_retain;
      for (int i = 0; i < 4; i++) rdc(8'hfb + 8'(i), 8'ha0 + 8'(i), 8'hff);
      rdc(8'hf3, 8'h03, 8'hff);
      rdc(8'h95, 8'h80, 8'hff);
      rdc(8'hf5, 8'h01, 8'hff);
      rdc(8'hd7, 8'h3c, 8'hff);
      tick(2);
      check(crd, 8'h5c);
      $display("retention done");
   endtask : t_retain

   task automatic t_restore;
      int n;
      met = 0;
      vdd = 1;
      wait_st(PSS_RESTORE_WAIT);
      for (n = 0; n < 100 && st !== 3'(PSS_NORMAL); n++) tick(1);
      check({7'h0, n >= RC && n <= RC + 1}, 8'h01);
      check({4'h0, main, ana, dig, crn}, 8'h0f);
      rdc(8'hf4, 8'h40, 8'h40);
      $display("restore done");
   endtask : t_restore

   initial begin
      tick(10);
      rstn_i = 1;
      tick(1);
      t_regs();
      t_battery();
      t_sleep(1'b1);
      t_sleep(1'b0);
      t_retain();
      t_restore();
      stop_test();
   end

   // Whole run is near 350 cycles; this cuts a hang after 25000
   initial begin
      #200000;
      fails++;
      stop_test();
   end
endmodule : pss_sequencer_bench
`default_nettype wire
